// ===== pmrc_checker.sv
// Purpose: Link checker for power and rate control
// Assumes: One clock, sync active-low reset
// Notes: Shadows device registers from link writes
`timescale 1ns/10ps
module pmrc_checker
  import pmrc_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Link signals
  input wire logic req,
  input wire logic wr,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic ack,
  input wire logic [7:0] rdata
);
  logic [7:0] rate_r;
  logic [7:0] pwr_r;
  logic rd_q_r;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  // Register shadows and read marker
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      rate_r <= PMRC_RATE_RST;
      pwr_r <= PMRC_PWR_RST;
      rd_q_r <= 1'b0;
    end
    else
    begin
      if (req && wr && addr == PMRC_ADDR_RATE)
        rate_r <= wdata;
      if (req && wr && addr == PMRC_ADDR_PWR)
        pwr_r <= wdata;
      rd_q_r <= req && !wr;
    end
  end
  // ==========================================================
  // Link rules
  AST_ACK_NEXT: assert property (req |=> ack)
    else $error("no ack after request");
  AST_NO_STRAY_ACK: assert property (ack |-> $past(req))
    else $error("ack without request");
  AST_REQ_PULSE: assert property (req |=> !req)
    else $error("request longer than one cycle");
  AST_ONE_FLIGHT: assert property (ack |-> !req)
    else $error("request while one in flight");
  AST_UNMAPPED: assert property (req && !wr && addr != PMRC_ADDR_RATE
    && addr != PMRC_ADDR_PWR |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  AST_RATE_RD: assert property (req && !wr && addr == PMRC_ADDR_RATE
    |=> rdata[4:0] == rate_r[4:0])
    else $error("rate register read wrong");
  AST_PWR_RD: assert property (req && !wr && addr == PMRC_ADDR_PWR
    |=> rdata[3] == pwr_r[3])
    else $error("measure bit read wrong");
  AST_RD_HOLD: assert property (!rd_q_r |-> $stable(rdata))
    else $error("read data moved without read");
endmodule

// ===== pmrc_device.sv
// Purpose: Device end: power state, low power and rate selection
// Assumes: Register link from host, 20 MHz clock, sync reset
// Notes: Sample tick period doubles per lower rate code
//
// Notes on behaviour
// - Reset starts in standby, sensing off
// - Measure bit one enters measurement
// - Measure bit zero returns to standby
// - Standby accepts all register reads, writes
// - Host configures first, then sets measure
// - Sensor functions only in measurement
// - Low power bit lowers internal sampling
// - Rate code selects rate, halving per step
// - Low power codes 0111..1100 keep mapping
// - Host uses low power only those codes
// - Self-test valid only normal power, settles 4
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/10ps
module pmrc_device
  import pmrc_pkg::*;
#(
  parameter int TICK_CYC = PMRC_TOP_TICK_CYC
)
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Register link
  pmrc_link_if.dev link,
  // Self-test request from sensing core
  input wire logic i_self_test,
  // Status toward sensing core
  output logic o_measuring,
  output logic o_sample_tick,
  output logic o_internal_tick,
  output logic [3:0] o_rate_code,
  output logic o_low_power,
  output logic o_self_test_ok,
  output logic o_self_test_settled
);
  import pmrc_pkg::*;

  typedef enum logic [0:0] {PMRC_STANDBY = 1'b0, PMRC_MEASURE = 1'b1}
    pmrc_state_type;

  // ==========================================================
  // Register file
  logic [7:0] rate_r, rate_nxt;
  logic [7:0] pwr_r, pwr_nxt;
  logic ack_r, ack_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  pmrc_state_type state_r, state_nxt;

  // Register access, accepted in any state
  always_comb
  begin
    rate_nxt = rate_r;
    pwr_nxt = pwr_r;
    ack_nxt = link.req;
    rdata_nxt = rdata_r;
    if (link.req && link.wr)
    begin
      if (link.addr == PMRC_ADDR_RATE)
        rate_nxt = link.wdata;
      else if (link.addr == PMRC_ADDR_PWR)
        pwr_nxt = link.wdata;
    end
    else if (link.req)
    begin
      if (link.addr == PMRC_ADDR_RATE)
        rdata_nxt = rate_r;
      else if (link.addr == PMRC_ADDR_PWR)
        rdata_nxt = pwr_r;
      else
        rdata_nxt = 8'h00;
    end
  end

  // Power state follows measure bit
  always_comb
  begin
    if (pwr_r[PMRC_MEASURE_BIT])
      state_nxt = PMRC_MEASURE;
    else
      state_nxt = PMRC_STANDBY;
  end

  // Registers, standby after reset
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      rate_r <= PMRC_RATE_RST;
      pwr_r <= PMRC_PWR_RST;
      ack_r <= 1'b0;
      rdata_r <= 8'h00;
      state_r <= PMRC_STANDBY;
    end
    else
    begin
      rate_r <= rate_nxt;
      pwr_r <= pwr_nxt;
      ack_r <= ack_nxt;
      rdata_r <= rdata_nxt;
      state_r <= state_nxt;
    end
  end

  assign link.ack = ack_r;
  assign link.rdata = rdata_r;

  // ==========================================================
  // Rate timing
  logic [3:0] code;
  logic low_power;
  logic lp_useful;
  logic [31:0] base_r, base_nxt;
  logic [15:0] div_r, div_nxt;
  logic [15:0] period_m1;
  logic [1:0] settle_r, settle_nxt;
  logic st_prev_r, st_prev_nxt;
  logic settled_r, settled_nxt;
  logic tick_r, tick_nxt;
  logic itick_r, itick_nxt;
  logic base_done;

  assign code = rate_r[PMRC_RATE_LSB +: 4];
  assign low_power = rate_r[PMRC_LOWPWR_BIT];
  // Low power only shifts internal rate within useful codes
  assign lp_useful = low_power && (code >= PMRC_CODE_LP_MIN) &&
                     (code <= PMRC_CODE_LP_MAX);
  // Top code period is one base tick; each lower code doubles
  assign period_m1 = 16'((32'h1 << (PMRC_CODE_MAX - code)) - 32'h1);
  assign base_done = (base_r == 32'(TICK_CYC - 1));

  // Tick generation, stopped in standby
  always_comb
  begin
    base_nxt = base_r;
    div_nxt = div_r;
    tick_nxt = 1'b0;
    itick_nxt = 1'b0;
    settle_nxt = settle_r;
    settled_nxt = settled_r;
    st_prev_nxt = i_self_test;
    if (state_r == PMRC_STANDBY)
    begin
      base_nxt = 32'h0;
      div_nxt = 16'h0;
    end
    else
    begin
      base_nxt = base_done ? 32'h0 : base_r + 32'h1;
      if (base_done)
      begin
        // Internal sampling: every base tick, or every other one
        itick_nxt = lp_useful ? div_r[0] : 1'b1;
        if (div_r == period_m1)
        begin
          div_nxt = 16'h0;
          tick_nxt = 1'b1;
        end
        else
          div_nxt = div_r + 16'h1;
      end
    end
    // Self-test settling over four output periods
    if (i_self_test != st_prev_r)
    begin
      settle_nxt = 2'(PMRC_SETTLE_PERIODS - 1);
      settled_nxt = 1'b0;
    end
    else if (tick_r && !settled_r)
    begin
      if (settle_r == 2'h0)
        settled_nxt = 1'b1;
      else
        settle_nxt = settle_r - 2'h1;
    end
  end

  // Timing registers
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      base_r <= 32'h0;
      div_r <= 16'h0;
      tick_r <= 1'b0;
      itick_r <= 1'b0;
      settle_r <= 2'h0;
      settled_r <= 1'b1;
      st_prev_r <= 1'b0;
      o_measuring <= 1'b0;
      o_rate_code <= 4'h0;
      o_low_power <= 1'b0;
      o_self_test_ok <= 1'b0;
    end
    else
    begin
      base_r <= base_nxt;
      div_r <= div_nxt;
      tick_r <= tick_nxt;
      itick_r <= itick_nxt;
      settle_r <= settle_nxt;
      settled_r <= settled_nxt;
      st_prev_r <= st_prev_nxt;
      o_measuring <= (state_nxt == PMRC_MEASURE);
      o_rate_code <= rate_nxt[PMRC_RATE_LSB +: 4];
      o_low_power <= rate_nxt[PMRC_LOWPWR_BIT];
      o_self_test_ok <= !rate_nxt[PMRC_LOWPWR_BIT];
    end
  end

  assign o_sample_tick = tick_r;
  assign o_internal_tick = itick_r;
  assign o_self_test_settled = settled_r;
endmodule

// ===== pmrc_host.sv
// Purpose: Host end: APB slave turning commands into link accesses
// Assumes: Software sets configuration before the measure bit
// Notes: One link access in flight; busy until device acknowledges
`timescale 1ns/10ps
module pmrc_host
  import pmrc_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Register link
  pmrc_link_if.host link
);
  import pmrc_pkg::*;

  typedef enum logic [0:0] {PMRC_H_IDLE = 1'b0, PMRC_H_WAIT = 1'b1}
    pmrc_hstate_type;

  // ==========================================================
  // Host state
  pmrc_hstate_type st_r, st_nxt;
  logic req_r, req_nxt;
  logic wr_r, wr_nxt;
  logic [7:0] addr_r, addr_nxt;
  logic [7:0] wd_r, wd_nxt;
  logic [7:0] rd_r, rd_nxt;
  logic [31:0] prdata_nxt;
  logic pready_nxt, pslverr_nxt;
  logic access;
  logic commit;

  assign access = i_psel && i_penable && !o_pready;
  // Writes land only at the edge where pready is seen high
  assign commit = i_psel && i_penable && o_pready;

  // APB decode and link sequencing; software orders
  always_comb
  begin
    st_nxt = st_r;
    req_nxt = 1'b0;
    wr_nxt = wr_r;
    addr_nxt = addr_r;
    wd_nxt = wd_r;
    rd_nxt = rd_r;
    prdata_nxt = 32'h0;
    pready_nxt = access;
    pslverr_nxt = 1'b0;
    if (access && i_pwrite)
    begin
      // Write decode only flags the error with pready
      if (i_paddr != PMRC_APB_CMD && i_paddr != PMRC_APB_WDATA &&
          i_paddr != PMRC_APB_RDATA && i_paddr != PMRC_APB_STAT)
        pslverr_nxt = 1'b1;
    end
    else if (access)
    begin
      if (i_paddr == PMRC_APB_CMD)
        prdata_nxt = {22'h0, wr_r, 1'b0, addr_r};
      else if (i_paddr == PMRC_APB_WDATA)
        prdata_nxt = {24'h0, wd_r};
      else if (i_paddr == PMRC_APB_RDATA)
        prdata_nxt = {24'h0, rd_r};
      else if (i_paddr == PMRC_APB_STAT)
        prdata_nxt = {31'h0, st_r == PMRC_H_WAIT};
      else
        pslverr_nxt = 1'b1;
    end
    // Write effect at the completing edge
    if (commit && i_pwrite)
    begin
      if (i_paddr == PMRC_APB_CMD)
      begin
        if (i_pwdata[PMRC_CMD_GO_BIT] && st_r == PMRC_H_IDLE)
        begin
          req_nxt = 1'b1;
          wr_nxt = i_pwdata[PMRC_CMD_WR_BIT];
          addr_nxt = i_pwdata[7:0];
          st_nxt = PMRC_H_WAIT;
        end
      end
      else if (i_paddr == PMRC_APB_WDATA)
        wd_nxt = i_pwdata[7:0];
    end
    if (st_r == PMRC_H_WAIT && link.ack)
    begin
      st_nxt = PMRC_H_IDLE;
      if (!wr_r)
        rd_nxt = link.rdata;
    end
  end

  // Host registers
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      st_r <= PMRC_H_IDLE;
      req_r <= 1'b0;
      wr_r <= 1'b0;
      addr_r <= 8'h00;
      wd_r <= 8'h00;
      rd_r <= 8'h00;
      o_prdata <= 32'h0;
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
      req_r <= req_nxt;
      wr_r <= wr_nxt;
      addr_r <= addr_nxt;
      wd_r <= wd_nxt;
      rd_r <= rd_nxt;
      o_prdata <= prdata_nxt;
      o_pready <= pready_nxt;
      o_pslverr <= pslverr_nxt;
    end
  end

  assign link.req = req_r;
  assign link.wr = wr_r;
  assign link.addr = addr_r;
  assign link.wdata = wd_r;
endmodule

// ===== pmrc_link_if.sv
// Purpose: Register link between host controller and device
// Assumes: One clock, host issues one access at a time
// Notes: Device answers every access one cycle after the request
`timescale 1ns/10ps
interface pmrc_link_if;
  logic req;
  logic wr;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic ack;
  logic [7:0] rdata;
  modport host (output req, output wr, output addr, output wdata,
                input ack, input rdata);
  modport dev (input req, input wr, input addr, input wdata,
               output ack, output rdata);
endinterface

// ===== pmrc_pkg.sv
// Purpose: Shared constants for power mode and output rate control
// Assumes: 20 MHz system clock, 8-bit device registers
// Notes: Host side holds the device map; device side implements it
package pmrc_pkg;
  // ==========================================================
  // Device register map
  localparam logic [7:0] PMRC_ADDR_RATE = 8'h2c;
  localparam logic [7:0] PMRC_ADDR_PWR = 8'h2d;
  localparam int PMRC_RATE_LSB = 0;
  localparam int PMRC_LOWPWR_BIT = 4;
  localparam int PMRC_MEASURE_BIT = 3;
  localparam logic [7:0] PMRC_RATE_RST = 8'h0a;
  localparam logic [7:0] PMRC_PWR_RST = 8'h00;
  localparam logic [3:0] PMRC_CODE_LP_MIN = 4'h7;
  localparam logic [3:0] PMRC_CODE_LP_MAX = 4'hc;
  localparam logic [3:0] PMRC_CODE_MAX = 4'hf;
  // ==========================================================
  // Timing: base tick of the top rate (3200 Hz) in clock cycles
  localparam int PMRC_CLK_HZ = 20000000;
  localparam int PMRC_TOP_RATE_HZ = 3200;
  localparam int PMRC_TOP_TICK_CYC = PMRC_CLK_HZ / PMRC_TOP_RATE_HZ;
  localparam int PMRC_SETTLE_PERIODS = 4;
  // ==========================================================
  // Host APB register offsets
  localparam logic [7:0] PMRC_APB_CMD = 8'h00;
  localparam logic [7:0] PMRC_APB_WDATA = 8'h04;
  localparam logic [7:0] PMRC_APB_RDATA = 8'h08;
  localparam logic [7:0] PMRC_APB_STAT = 8'h0c;
  localparam int PMRC_CMD_GO_BIT = 8;
  localparam int PMRC_CMD_WR_BIT = 9;
endpackage

// ===== tb.sv
// Purpose: Bench for power mode and output rate control
// Assumes: Tick base of 4 cycles, host APB map
// Notes: Random low power choice, fixed seed
`timescale 1ns/10ps
module tb;
  import pmrc_pkg::*;
  localparam int TK = 4;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwd = 32'h0;
  logic st = 1'b0;
  logic [31:0] prd, rd;
  logic prdy, perr, err, meas, stk, itk, lp, stok, stset, l;
  logic [3:0] code, c;
  int bad_count = 0;
  int checked = 0;
  int n;
  pmrc_link_if link();
  // Clock
  always #25 i_clk = ~i_clk;
  // Both ends and the checker
  pmrc_host pmrc_host_inst (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr),
    .i_pwdata(pwd), .o_prdata(prd), .o_pready(prdy), .o_pslverr(perr),
    .link(link));
  pmrc_device #(.TICK_CYC(TK)) pmrc_device_inst (.i_clk(i_clk),
    .i_rst_n(i_rst_n), .link(link), .i_self_test(st), .o_measuring(meas),
    .o_sample_tick(stk), .o_internal_tick(itk), .o_rate_code(code),
    .o_low_power(lp), .o_self_test_ok(stok), .o_self_test_settled(stset));
  pmrc_checker pmrc_checker_inst (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .req(link.req), .wr(link.wr), .addr(link.addr), .wdata(link.wdata),
    .ack(link.ack), .rdata(link.rdata));
  // ==========================================================
  // Helpers
  function automatic int int_per(logic lo, logic [3:0] cd);
    return (lo && cd >= PMRC_CODE_LP_MIN && cd <= PMRC_CODE_LP_MAX) ?
      2 * TK : TK;
  endfunction
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict;
    if (bad_count == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    int k;
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwd <= d;
    @(posedge i_clk);
    pen <= 1'b1;
    k = 0;
    do
    begin
      @(posedge i_clk);
      k++;
    end
    while (prdy !== 1'b1 && k < 50);
    if (k >= 50)
      bad_count++;
    rd = prd;
    err = perr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge i_clk);
  endtask
  task automatic dev(input logic w, input logic [7:0] a,
    input logic [7:0] d);
    int k;
    if (w)
      apb(1'b1, PMRC_APB_WDATA, {24'h0, d});
    apb(1'b1, PMRC_APB_CMD, {22'h0, w, 1'b1, a});
    k = 0;
    do
    begin
      apb(1'b0, PMRC_APB_STAT, 32'h0);
      k++;
    end
    while (rd[0] !== 1'b0 && k < 20);
    if (!w)
      apb(1'b0, PMRC_APB_RDATA, 32'h0);
  endtask
  task automatic gap(input logic s, output int p);
    int k;
    k = 0;
    while ((s ? stk : itk) !== 1'b1 && k < 5000)
    begin
      @(posedge i_clk);
      k++;
    end
    p = 0;
    do
    begin
      @(posedge i_clk);
      p++;
    end
    while ((s ? stk : itk) !== 1'b1 && p < 5000);
  endtask
  // Watchdog
  initial
  begin
    repeat (40000) @(posedge i_clk);
    bad_count++;
    give_verdict();
  end
  // ==========================================================
  // Main sequence
  initial
  begin
    void'($urandom(2027));
    repeat (2) @(posedge i_clk);
    i_rst_n <= 1'b1;
    repeat (2) @(posedge i_clk);
    check(meas, 1'b0);
    check(code, PMRC_RATE_RST[3:0]);
    n = 0;
    repeat (40)
    begin
      @(posedge i_clk);
      n += stk + itk;
    end
    check(n, 0);
    apb(1'b0, 8'h10, 32'h0);
    check(err, 1'b1);
    dev(1'b0, PMRC_ADDR_RATE, 8'h00);
    check(rd, {24'h0, PMRC_RATE_RST});
    dev(1'b0, 8'h00, 8'h00);
    check(rd, 32'h0);
    dev(1'b0, PMRC_ADDR_PWR, 8'h00);
    check(rd[3], 1'b0);
    for (int i = 0; i < 10; i++)
    begin
      c = 4'(15 - i);
      l = (c == 4'h6 || c == 4'h7 || c == 4'hc || c == 4'hd) ? 1'b1 :
        1'($urandom % 2);
      dev(1'b1, PMRC_ADDR_RATE, {3'h0, l, c});
      dev(1'b0, PMRC_ADDR_RATE, 8'h00);
      check(rd[4:0], {l, c});
      check({lp, code}, {l, c});
      check(stok, !l);
      dev(1'b1, PMRC_ADDR_PWR, 8'h08);
      dev(1'b0, PMRC_ADDR_PWR, 8'h00);
      check(rd, 32'h08);
      check(meas, 1'b1);
      gap(1'b1, n);
      check(n, TK << (15 - c));
      gap(1'b0, n);
      check(n, int_per(l, c));
      dev(1'b1, PMRC_ADDR_PWR, 8'h00);
      dev(1'b0, PMRC_ADDR_PWR, 8'h00);
      check(rd, 32'h00);
      check(meas, 1'b0);
    end
    dev(1'b1, PMRC_ADDR_RATE, 8'h0f);
    dev(1'b1, PMRC_ADDR_PWR, 8'h08);
    // Self-test on, then off: settled drops, returns in four periods
    repeat (2)
    begin
      st <= ~st;
      repeat (2) @(posedge i_clk);
      check(stset, 1'b0);
      n = 0;
      while (stset !== 1'b1 && n < 100)
      begin
        @(posedge i_clk);
        n++;
      end
      check(n > 3 * TK && n <= 4 * TK, 1'b1);
    end
    // Reset in mid-run returns to standby and reset rate
    i_rst_n <= 1'b0;
    repeat (2) @(posedge i_clk);
    i_rst_n <= 1'b1;
    repeat (2) @(posedge i_clk);
    check(meas, 1'b0);
    dev(1'b0, PMRC_ADDR_RATE, 8'h00);
    check(rd, {24'h0, PMRC_RATE_RST});
    give_verdict();
  end
endmodule
